// file: ssd_pkg.sv
// constants and types for the synchronous sram cycle decoder
package ssd_pkg;

    // ----------------------------------------------------------------
    // widths and layout
    // ----------------------------------------------------------------
    localparam int LANES = 4;                   // byte lanes a..d
    localparam int LANE_BITS = 8;               // data bits per lane
    localparam int LANE_W = LANE_BITS + 1;      // data plus parity bit
    localparam int DATA_W = LANES * LANE_BITS;
    localparam int WORD_W = DATA_W + LANES;     // {parity, data}
    localparam int ADDR_W = 10;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int BCNT_W = 2;                  // burst of up to four

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [BCNT_W-1:0] BCNT_ZERO = 2'h0;
    localparam logic [BCNT_W-1:0] BCNT_ONE = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [WORD_W-1:0] WORD_ZERO = 36'h0_0000_0000;
    localparam int SLEEP_CYCLES = 2;            // cycles to enter or leave sleep
    localparam logic [1:0] SLEEP_CNT_LAST = 2'(SLEEP_CYCLES - 1);
    localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;

    // ----------------------------------------------------------------
    // burst state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BURST_IDLE = 2'b00,
        BURST_READ = 2'b01,
        BURST_WRITE = 2'b10
    } ssd_burst_t;

endpackage : ssd_pkg

// file: ssd_mem_if.sv
// interface between the cycle decoder and the lane memory
`timescale 1ns/1ps
interface ssd_mem_if import ssd_pkg::*; ();
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0] wr_lane_en;
    logic [WORD_W-1:0] wr_word;
    logic [ADDR_W-1:0] rd_addr;
    logic [WORD_W-1:0] rd_word;

    modport ctrl (output wr_en, wr_addr, wr_lane_en, wr_word, rd_addr, input rd_word);
    modport mem (input wr_en, wr_addr, wr_lane_en, wr_word, rd_addr, output rd_word);
endinterface : ssd_mem_if

// file: ssd_lane_mem.sv
// byte-lane storage array with per-lane write masking
`timescale 1ns/1ps
module ssd_lane_mem import ssd_pkg::*; (
    input wire logic sys_clk,
    ssd_mem_if.mem m
);

    // ----------------------------------------------------------------
    // one array per lane, each lane written only when its enable is set
    // ----------------------------------------------------------------
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [LANE_W-1:0] store_q [DEPTH];
        logic [LANE_W-1:0] lane_wr;

        // lane slice of the word: parity bit above the data byte
        assign lane_wr = {m.wr_word[DATA_W + i], m.wr_word[i*LANE_BITS +: LANE_BITS]};

        // unselected lanes keep their contents
        always_ff @(posedge sys_clk) begin
            if (m.wr_en && m.wr_lane_en[i]) begin
                store_q[m.wr_addr] <= lane_wr;
            end
        end

        // asynchronous read, registered by the decoder
        assign m.rd_word[i*LANE_BITS +: LANE_BITS] = store_q[m.rd_addr][LANE_BITS-1:0];
        assign m.rd_word[DATA_W + i] = store_q[m.rd_addr][LANE_BITS];
    end

endmodule : ssd_lane_mem

// file: ssd_cycle_decode.sv
// cycle decoder, burst control and output enable gating of the sram
`timescale 1ns/1ps
// What this block does
// - load with any chip select inactive deselects; later continues keep deselect
// - load, all selects, write select high: read burst at external address
// - advance during read burst reads next address, ignoring selects
// - read start with output enable off reads but leaves lines floating
// - read continue with output enable off advances without driving
// - load, all selects, write select low, a lane low: write burst
// - advance during write burst writes next address, ignoring selects
// - write start with no lanes selected writes nothing, lines float
// - write continue with no lanes advances address, stores nothing
// - clock gate high while not asleep: edge ignored, all state but the sleep synchroniser and timer held
// - any write cycle floats every data and parity line
// - output enable acts combinationally on drivers
// - output enable masked internally during write data phase
// - read data driven only while output enable active and selected
// - after reset deselected with all lines floating
// - each low lane select writes its byte plus parity bit
// - any lane combination accepted; unselected lanes unchanged
// - sleep request floats outputs, two cycles to enter or leave
// - burst order input picks linear or interleaved, both wrapping
// - burst of up to four keeps access type from its start
// - write data latched second rise; outputs float on first
module ssd_cycle_decode import ssd_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clock_gate_n,
    input wire logic ce1_n,
    input wire logic ce2,
    input wire logic ce3_n,
    input wire logic advance_or_load,
    input wire logic write_en_n,
    input wire logic [LANES-1:0] byte_lane_write_select_n,
    input wire logic output_en_n,
    input wire logic sleep_request,
    input wire logic burst_order_sel,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [LANES-1:0] parity_lines_in,
    output logic [LANES-1:0] parity_lines_out,
    output logic parity_lines_oe
);

    ssd_mem_if mbus ();

    // ----------------------------------------------------------------
    // sleep request synchroniser and entry/exit timer
    // ----------------------------------------------------------------
    logic sleep_meta_q, sleep_sync_q;
    logic asleep_q, asleep_d;
    logic [1:0] sleep_cnt_q, sleep_cnt_d;

    // asleep follows the synced request after it has been steady two cycles
    always_comb begin
        asleep_d = asleep_q;
        sleep_cnt_d = SLEEP_CNT_ZERO;
        if (sleep_sync_q != asleep_q) begin
            if (sleep_cnt_q == SLEEP_CNT_LAST) begin
                asleep_d = sleep_sync_q;
            end else begin
                sleep_cnt_d = 2'(sleep_cnt_q + 2'h1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_meta_q <= 1'b0;
            sleep_sync_q <= 1'b0;
            asleep_q <= 1'b0;
            sleep_cnt_q <= SLEEP_CNT_ZERO;
        end else begin
            sleep_meta_q <= sleep_request;
            sleep_sync_q <= sleep_meta_q;
            asleep_q <= asleep_d;
            sleep_cnt_q <= sleep_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // cycle decode and burst counter
    // ----------------------------------------------------------------
    ssd_burst_t burst_q, burst_d;
    logic [ADDR_W-1:0] base_q, base_d;
    logic [BCNT_W-1:0] cnt_q, cnt_d;
    logic [BCNT_W-1:0] nxt_cnt, nxt_low;
    logic [ADDR_W-1:0] nxt_addr;
    logic go, all_ce, any_lane;
    logic iss_rd, iss_wr;
    logic [ADDR_W-1:0] iss_addr;
    logic [LANES-1:0] iss_lanes;

    assign go = !clock_gate_n && !asleep_q;
    assign all_ce = !ce1_n && ce2 && !ce3_n;
    assign any_lane = !(&byte_lane_write_select_n);
    assign nxt_cnt = 2'(cnt_q + BCNT_ONE);
    // interleaved order xors the count in, linear order adds it; both wrap
    assign nxt_low = burst_order_sel ? (base_q[BCNT_W-1:0] ^ nxt_cnt)
                                     : 2'(base_q[BCNT_W-1:0] + nxt_cnt);
    assign nxt_addr = {base_q[ADDR_W-1:BCNT_W], nxt_low};

    // choose this edge's operation from the sampled controls
    always_comb begin
        burst_d = burst_q;
        base_d = base_q;
        cnt_d = cnt_q;
        iss_rd = 1'b0;
        iss_wr = 1'b0;
        iss_addr = addr;
        iss_lanes = ~byte_lane_write_select_n;
        if (asleep_q) begin
            burst_d = BURST_IDLE;
        end else if (go && !advance_or_load) begin
            base_d = addr;
            cnt_d = BCNT_ZERO;
            if (!all_ce) begin
                burst_d = BURST_IDLE;
            end else if (write_en_n) begin
                burst_d = BURST_READ;
                iss_rd = 1'b1;
            end else begin
                burst_d = BURST_WRITE;
                iss_wr = any_lane;
            end
        end else if (go) begin
            // advance ignores chip selects and write select
            unique case (burst_q)
                BURST_IDLE: begin
                    burst_d = BURST_IDLE;
                end
                BURST_READ: begin
                    cnt_d = nxt_cnt;
                    iss_rd = 1'b1;
                    iss_addr = nxt_addr;
                end
                BURST_WRITE: begin
                    cnt_d = nxt_cnt;
                    iss_wr = any_lane;
                    iss_addr = nxt_addr;
                end
                default: begin
                    burst_d = BURST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_q <= BURST_IDLE;
            base_q <= ADDR_ZERO;
            cnt_q <= BCNT_ZERO;
        end else begin
            burst_q <= burst_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // two-stage pipeline: read data out after first rise, write data
    // taken on second rise
    // ----------------------------------------------------------------
    logic s1_rd_q, s1_rd_d, s1_wr_q, s1_wr_d;
    logic [ADDR_W-1:0] s1_addr_q, s1_addr_d;
    logic [LANES-1:0] s1_lanes_q, s1_lanes_d;
    logic s2_wr_q, s2_wr_d;
    logic [ADDR_W-1:0] s2_addr_q, s2_addr_d;
    logic [LANES-1:0] s2_lanes_q, s2_lanes_d;
    logic drive_q, drive_d;
    logic [WORD_W-1:0] rdata_q, rdata_d;

    // stages move only on edges that are not gated
    always_comb begin
        s1_rd_d = s1_rd_q;
        s1_wr_d = s1_wr_q;
        s1_addr_d = s1_addr_q;
        s1_lanes_d = s1_lanes_q;
        s2_wr_d = s2_wr_q;
        s2_addr_d = s2_addr_q;
        s2_lanes_d = s2_lanes_q;
        drive_d = drive_q;
        rdata_d = rdata_q;
        if (asleep_q) begin
            s1_rd_d = 1'b0;
            s1_wr_d = 1'b0;
            s2_wr_d = 1'b0;
            drive_d = 1'b0;
        end else if (go) begin
            s1_rd_d = iss_rd;
            s1_wr_d = iss_wr;
            s1_addr_d = iss_addr;
            s1_lanes_d = iss_lanes;
            s2_wr_d = s1_wr_q;
            s2_addr_d = s1_addr_q;
            s2_lanes_d = s1_lanes_q;
            drive_d = s1_rd_q;
            if (s1_rd_q) begin
                rdata_d = mbus.rd_word;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_rd_q <= 1'b0;
            s1_wr_q <= 1'b0;
            s1_addr_q <= ADDR_ZERO;
            s1_lanes_q <= LANES_NONE;
            s2_wr_q <= 1'b0;
            s2_addr_q <= ADDR_ZERO;
            s2_lanes_q <= LANES_NONE;
            drive_q <= 1'b0;
            rdata_q <= WORD_ZERO;
        end else begin
            s1_rd_q <= s1_rd_d;
            s1_wr_q <= s1_wr_d;
            s1_addr_q <= s1_addr_d;
            s1_lanes_q <= s1_lanes_d;
            s2_wr_q <= s2_wr_d;
            s2_addr_q <= s2_addr_d;
            s2_lanes_q <= s2_lanes_d;
            drive_q <= drive_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // memory port and pin drivers
    // ----------------------------------------------------------------
    assign mbus.rd_addr = s1_addr_q;
    assign mbus.wr_en = go && s2_wr_q;
    assign mbus.wr_addr = s2_addr_q;
    assign mbus.wr_lane_en = s2_lanes_q;
    assign mbus.wr_word = {parity_lines_in, data_in};

    ssd_lane_mem u_mem (
        .sys_clk(sys_clk),
        .m(mbus.mem)
    );

    assign data_out = rdata_q[DATA_W-1:0];
    assign parity_lines_out = rdata_q[WORD_W-1:DATA_W];
    // output enable gates the drivers without a register; write phase masks it
    assign data_oe = drive_q && !output_en_n && !s2_wr_q && !asleep_q;
    assign parity_lines_oe = data_oe;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_stall_holds_state: assert property (clock_gate_n && !asleep_q |=>
        $stable(cnt_q) && $stable(s1_rd_q) && $stable(s2_wr_q) && $stable(drive_q))
        else $error("gated edge changed pipeline state");
    a_write_no_drive: assert property (s2_wr_q |-> !drive_q && !data_oe && !parity_lines_oe)
        else $error("drivers on during write data phase");
    a_oe_off_floats: assert property (output_en_n |-> !data_oe)
        else $error("data driven with output enable off");
    a_read_drives_next: assert property (
        (go && !advance_or_load && all_ce && write_en_n) ##1 (go && !output_en_n)
        |=> (data_oe || output_en_n || asleep_q))
        else $error("read begin did not drive data");
    a_deselect_floats: assert property (
        (go && !advance_or_load && !all_ce) ##1 go |=> !drive_q)
        else $error("deselect cycle drove data");
    a_abort_no_write: assert property (
        (go && !advance_or_load && all_ce && !write_en_n && !any_lane) ##1 go ##1 go
        |-> !mbus.wr_en)
        else $error("write abort stored data");
    a_lanes_match: assert property (
        (go && !advance_or_load && all_ce && !write_en_n && any_lane) ##1 go ##1 go
        |-> mbus.wr_en && mbus.wr_lane_en == ~$past(byte_lane_write_select_n, 2))
        else $error("write lanes differ from lane selects");
    a_burst_advance: assert property (
        go && advance_or_load && burst_q != BURST_IDLE
        |=> cnt_q == 2'($past(cnt_q) + BCNT_ONE) && $stable(burst_q))
        else $error("burst count did not advance");
    a_burst_order: assert property (
        go && advance_or_load && burst_q == BURST_READ && burst_order_sel
        |=> s1_addr_q[BCNT_W-1:0] == ($past(base_q[BCNT_W-1:0]) ^ cnt_q))
        else $error("interleaved order wrong");
    a_sleep_floats: assert property (
        sleep_sync_q && !asleep_q ##1 sleep_sync_q |=> asleep_q ##0 !data_oe)
        else $error("sleep entry took wrong time");
    // a read load is performed even with output enable off
    a_dummy_read_loads: assert property (
        (go && !advance_or_load && all_ce && write_en_n) ##1 go |=> drive_q)
        else $error("read load did not reach the output stage");
    // a write continue with no lanes selected must not store anything
    a_cont_abort_quiet: assert property (
        (go && advance_or_load && burst_q == BURST_WRITE && !any_lane) ##1 go ##1 go
        |-> !mbus.wr_en)
        else $error("write abort continue stored data");
    // leaving sleep finds the burst and pipeline empty
    a_wake_clears_pipe: assert property (
        $fell(asleep_q) |-> burst_q == BURST_IDLE && !drive_q && !s1_rd_q && !s2_wr_q)
        else $error("pipeline not cleared by sleep");

endmodule : ssd_cycle_decode

// file: ssd_host_model.sv
// host side model that presents write data for the sram cycle decoder
`timescale 1ns/1ps
module ssd_host_model import ssd_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clock_gate_n,
    input wire logic wr_valid,
    input wire logic [WORD_W-1:0] wr_word,
    output logic [DATA_W-1:0] data_in,
    output logic [LANES-1:0] parity_lines_in
);
    // ----------------------------------------------------------------
    // write data pipeline
    // ----------------------------------------------------------------
    logic [WORD_W:0] p1_q;
    logic [WORD_W:0] p2_q;
    logic alt_q;
    logic [WORD_W-1:0] word;

    // shifts only on taken rises, so a stalled rise holds the data
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            p1_q <= '0;
            p2_q <= '0;
            alt_q <= 1'b0;
        end else begin
            alt_q <= ~alt_q;
            if (!clock_gate_n) begin
                p1_q <= {wr_valid, wr_word};
                p2_q <= p1_q;
            end
        end
    end

    // data of the command two taken rises back, else a changing pattern
    assign word = p2_q[WORD_W] ? p2_q[WORD_W-1:0] : {WORD_W{alt_q}};
    assign data_in = word[DATA_W-1:0];
    assign parity_lines_in = word[WORD_W-1:DATA_W];
endmodule : ssd_host_model

// file: testbench.sv
// self-checking bench for the sram cycle decoder
`timescale 1ns/1ps
module testbench import ssd_pkg::*; ;
    // ----------------------------------------------------------------
    // stimulus and design signals
    // ----------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clock_gate_n = 1'b0;
    logic ce1_n = 1'b1;
    logic ce2 = 1'b0;
    logic ce3_n = 1'b1;
    logic advance_or_load = 1'b0;
    logic write_en_n = 1'b1;
    logic [LANES-1:0] byte_lane_write_select_n = 4'hF;
    logic output_en_n = 1'b0;
    logic sleep_request = 1'b0;
    logic burst_order_sel = 1'b0;
    logic [ADDR_W-1:0] addr = 10'h000;
    logic wr_valid = 1'b0;
    logic [WORD_W-1:0] wr_word = 36'h0_0000_0000;
    logic [DATA_W-1:0] data_in;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
    logic [LANES-1:0] parity_lines_in;
    logic [LANES-1:0] parity_lines_out;
    logic parity_lines_oe;
    // model state
    logic [WORD_W-1:0] mem [DEPTH];
    logic [WORD_W-1:0] exp_d;
    logic [WORD_W-1:0] w1w;
    logic [WORD_W-1:0] w2w;
    logic [3:0] w1l;
    logic [3:0] w2l;
    logic [9:0] bad;
    logic [31:0] seed = 32'h0000_000A;
    logic [31:0] r;
    bit exp_drv, rq_v, w1v, w2v, chk = 1, asleep, bsel, slp;
    int btype, bk, rq_a, w1a, w2a, op, n_fail, cmp_count, cyc;

    ssd_cycle_decode uut (.sys_clk(sys_clk), .rst_n(rst_n), .clock_gate_n(clock_gate_n),
        .ce1_n(ce1_n), .ce2(ce2), .ce3_n(ce3_n), .advance_or_load(advance_or_load),
        .write_en_n(write_en_n), .byte_lane_write_select_n(byte_lane_write_select_n),
        .output_en_n(output_en_n), .sleep_request(sleep_request),
        .burst_order_sel(burst_order_sel), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .parity_lines_in(parity_lines_in),
        .parity_lines_out(parity_lines_out), .parity_lines_oe(parity_lines_oe));

    ssd_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .clock_gate_n(clock_gate_n),
        .wr_valid(wr_valid), .wr_word(wr_word), .data_in(data_in),
        .parity_lines_in(parity_lines_in));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic cmp(string nm, logic [WORD_W-1:0] seen, logic [WORD_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : cmp

    task automatic end_sim();
        if (n_fail == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim

    // model of one taken rise: read result, landing write, then decode
    task automatic step();
        logic [WORD_W-1:0] m;
        int a;
        if (clock_gate_n || asleep) return;
        exp_drv = rq_v;
        if (rq_v) exp_d = mem[rq_a];
        if (w2v) begin
            m = mem[w2a];
            for (int l = 0; l < LANES; l++) begin
                if (!w2l[l]) begin
                    m[8*l+:8] = w2w[8*l+:8];
                    m[DATA_W+l] = w2w[DATA_W+l];
                end
            end
            mem[w2a] = m;
        end
        {w2v, w2a, w2l, w2w} = {w1v, w1a, w1l, w1w};
        if (!advance_or_load) begin
            btype = (ce1_n || !ce2 || ce3_n) ? 0 : (write_en_n ? 1 : 2);
            bad = addr;
            bk = 0;
        end else if (btype != 0) bk = (bk + 1) % 4;
        a = {bad[9:2], burst_order_sel ? bad[1:0] ^ 2'(bk) : bad[1:0] + 2'(bk)};
        rq_v = (btype == 1);
        rq_a = a;
        w1v = (btype == 2) && byte_lane_write_select_n != 4'hF;
        {w1a, w1l, w1w} = {a, byte_lane_write_select_n, wr_word};
    endtask : step

    // one bus cycle: op 0 deselect, 1-2 read, 3 write, 4-6 advance, 7 stall
    task automatic cycle(int o, int a, bit full);
        logic [31:0] q;
        logic [3:0] ln;
        @(posedge sys_clk);
        step();
        q = xs();
        ln = full ? 4'h0 : q[7:4];
        clock_gate_n <= (o == 7);
        advance_or_load <= (o >= 4);
        {ce1_n, ce2, ce3_n} <= (o == 0 && q[2:0] == 3'h2) ? 3'h0 : (o inside {[1:3]} ? 3'h2 : q[2:0]);
        write_en_n <= (o == 3) ? 1'b0 : (o inside {1, 2} ? 1'b1 : q[3]);
        byte_lane_write_select_n <= ln;
        output_en_n <= q[8];
        addr <= 10'(a);
        wr_word <= {q[12:9], xs()};
        wr_valid <= (o == 3 || (o inside {[4:6]} && btype == 2)) && ln != 4'hF;
        burst_order_sel <= bsel;
        sleep_request <= slp;
        @(negedge sys_clk);
        if (chk) begin
            cmp("data_oe", WORD_W'(data_oe), WORD_W'(exp_drv && !output_en_n));
            cmp("parity_oe", WORD_W'(parity_lines_oe), WORD_W'(exp_drv && !output_en_n));
            if (exp_drv) cmp("rdata", {parity_lines_out, data_out}, exp_d);
        end
    endtask : cycle

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        cmp("oe_in_reset", WORD_W'(data_oe), WORD_W'(1'b0));
        rst_n <= 1'b1;
        for (int i = 0; i < 32; i++) cycle(i % 4 ? 4 : 3, i, 1'b1);
        for (int k = 0; k < 2; k++) begin
            bsel = k[0];
            repeat (3) cycle(0, 0, 1'b0);
            repeat (1500) begin
                r = xs();
                op = int'(r[2:0]);
                cycle(op, op == 3 ? 16 + int'(r[6:3]) : int'(r[6:3]), 1'b0);
            end
        end
        repeat (4) cycle(0, 0, 1'b0);
        chk = 0;
        slp = 1'b1;
        repeat (8) cycle(0, 0, 1'b0);
        asleep = 1;
        exp_drv = 0;
        chk = 1;
        repeat (6) cycle(1, 0, 1'b0);
        chk = 0;
        slp = 1'b0;
        repeat (8) cycle(0, 0, 1'b0);
        {asleep, rq_v, w1v, w2v, btype} = '0;
        chk = 1;
        repeat (300) begin
            r = xs();
            op = (r[2:0] == 3'h3) ? 1 : int'(r[2:0]);
            cycle(op, 16 + int'(r[6:3]), 1'b0);
        end
        end_sim();
    end

    // cut a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_fail++;
            end_sim();
        end
    end
endmodule : testbench
